// ### pbm_mgmt_regs.sv
// Basic control, status and identifier registers behind the serial port
//
// Summary of operation
// - Writing control bit 15 restores defaults; bit self-clears and reads zero.
// - Control bit 14 loops transmit nibbles back to the receive path.
// - Control bit 13 selects 100Mbps when one, 10Mbps when zero; resets one.
// - In fiber mode the speed bit reads one and ignores writes.
// - In fiber mode negotiation enable reads zero and ignores writes.
// - With negotiation on, the speed bit still drives speed; duplex follows the resolved value once done; enable resets one.
// - Writing one to control bit 9 restarts negotiation unless bit 15 is also set; resets zero.
// - Bit 8 forces duplex when negotiation off; reports resolved duplex after.
// - Status bits 15..11 are fixed abilities; T4 zero, other four one.
// - Status bit 5 shows negotiation complete; resets zero.
// - Status bit 4 latches remote fault, clears on read; fiber shows far-end fault.
// - Status bit 3 reads one until a link failure occurs; resets one.
// - Status bit 2 shows valid link; resets zero.
// - Status bit 1 shows jabber detected; resets zero.
// - Status bit 0 always reads one.
// - The five-bit management address is captured from straps on the first clock after reset release.
`timescale 1ns/1ps
module pbm_mgmt_regs #(
  parameter logic [15:0] ID_HIGH_VALUE = 16'h1234, // Arbitrary value
  parameter logic [15:0] ID_LOW_VALUE  = 16'h5678  // Arbitrary value
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_o,
  input  wire logic [4:0] mgmt_address_strap_i,
  input  wire logic       fiber_mode_i,
  input  wire logic       aneg_done_i,
  input  wire logic       aneg_duplex_i,
  input  wire logic       remote_fault_i,
  input  wire logic       link_up_i,
  input  wire logic       jabber_i,
  output logic            loopback_o,
  output logic            speed_100_o,
  output logic            full_duplex_o,
  output logic            aneg_enable_o,
  output logic            aneg_restart_o,
  output logic            power_down_o,
  output logic [4:0]      mgmt_address_o
);
  import pbm_pkg::*;

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  logic mdc_s;
  logic mdio_s;
  logic fiber_s;
  logic done_s;
  logic adup_s;
  logic rflt_s;
  logic link_s;
  logic jab_s;

  localparam int NSYNC = 8;
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_out;
  assign sync_in = {mdc_i, mdio_i, fiber_mode_i, aneg_done_i,
                    aneg_duplex_i, remote_fault_i, link_up_i, jabber_i};
  assign {mdc_s, mdio_s, fiber_s, done_s, adup_s, rflt_s, link_s, jab_s}
    = sync_out;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      pbm_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .async_i   (sync_in[gi]),
        .sync_o    (sync_out[gi])
      );
    end
  endgenerate

  // ********************************************************************
  // Address strap capture after reset release
  // ********************************************************************
  logic       strap_done_r;
  logic [4:0] addr_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_done_r <= 1'b0;
      addr_r       <= 5'h00;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      addr_r       <= mgmt_address_strap_i;
    end
  end
  assign mgmt_address_o = addr_r;

  // ********************************************************************
  // Clock edge detect
  // ********************************************************************
  logic mdc_d_r;
  logic mdc_rise;
  logic mdc_fall;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mdc_d_r <= 1'b0;
    end else begin
      mdc_d_r <= mdc_s;
    end
  end
  assign mdc_rise = mdc_s & ~mdc_d_r;
  assign mdc_fall = ~mdc_s & mdc_d_r;

  // ********************************************************************
  // Frame state machine
  // ********************************************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_HEAD = 6'b000010,
    ST_TA   = 6'b000100,
    ST_RDAT = 6'b001000,
    ST_WDAT = 6'b010000,
    ST_SKIP = 6'b100000
  } pbm_state_type;

  pbm_state_type state_r;
  logic [5:0]    pre_cnt_r;
  logic          pre_ok_r;
  logic [4:0]    bit_cnt_r;
  logic [13:0]   head_r;
  logic [15:0]   shift_r;
  logic [4:0]    reg_r;
  logic          wr_strobe;
  logic          rd_strobe;
  logic [15:0]   rd_data;
  logic [13:0]   head_nxt;

  assign head_nxt = {head_r[12:0], mdio_s};

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_cnt_r <= 6'h00;
      pre_ok_r  <= 1'b0;
    end else if (mdc_rise && state_r == ST_IDLE) begin
      if (!mdio_s) begin
        pre_cnt_r <= 6'h00;
      end else if (pre_cnt_r != PBM_PREAMBLE_MIN) begin
        pre_cnt_r <= pre_cnt_r + 6'h01;
      end
      if (pre_cnt_r == PBM_PREAMBLE_MIN) begin
        pre_ok_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 5'h00;
      head_r    <= 14'h0000;
      reg_r     <= 5'h00;
      shift_r   <= 16'h0000;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else begin
      if (mdc_rise) begin
        case (state_r)
          ST_IDLE: begin
            // Start bit 0 after idle ones; later frames need no preamble
            if (!mdio_s && (pre_ok_r || pre_cnt_r == PBM_PREAMBLE_MIN)) begin
              head_r    <= 14'h0000;
              bit_cnt_r <= 5'h00;
              state_r   <= ST_HEAD;
            end
          end
          ST_HEAD: begin
            head_r    <= head_nxt;
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'h0C) begin
              reg_r <= head_nxt[4:0];
              if (head_nxt[12] != PBM_ST_CODE[0]
                  || head_nxt[9:5] != addr_r) begin
                state_r <= ST_SKIP;
              end else begin
                state_r <= ST_TA;
              end
              bit_cnt_r <= 5'h00;
            end
          end
          ST_TA: begin
            bit_cnt_r <= 5'h00;
            if (head_r[11:10] == PBM_OP_READ) begin
              shift_r <= rd_data;
              state_r <= ST_RDAT;
            end else begin
              state_r <= ST_WDAT;
            end
          end
          ST_RDAT: begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'h10) begin
              state_r <= ST_IDLE;
            end
          end
          ST_WDAT: begin
            shift_r   <= {shift_r[14:0], mdio_s};
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'h10) begin
              state_r <= ST_IDLE;
            end
          end
          ST_SKIP: begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'h11) begin
              state_r <= ST_IDLE;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
      // Drive read data on falling clock, zero during second turnaround bit
      if (mdc_fall) begin
        if (state_r == ST_RDAT && bit_cnt_r < 5'h10) begin
          mdio_oe_o <= 1'b1;
          mdio_o    <= (bit_cnt_r == 5'h00) ? 1'b0 : shift_r[15];
          if (bit_cnt_r != 5'h00) begin
            shift_r <= {shift_r[14:0], 1'b0};
          end
        end else if (state_r == ST_RDAT && bit_cnt_r == 5'h10) begin
          mdio_o <= shift_r[15];
        end else begin
          mdio_oe_o <= 1'b0;
          mdio_o    <= 1'b0;
        end
      end
    end
  end

  // Write lands after the sixteenth data bit; read snapshot at turnaround
  assign wr_strobe = mdc_rise && state_r == ST_WDAT && bit_cnt_r == 5'h10
                     && head_r[11:10] == PBM_OP_WRITE;
  assign rd_strobe = mdc_rise && state_r == ST_TA
                     && head_r[11:10] == PBM_OP_READ;

  // ********************************************************************
  // Control register
  // ********************************************************************
  logic [15:0] wdata;
  logic        ctl_wr;
  logic        soft_reset;
  logic        restart_r;

  assign wdata      = {shift_r[14:0], mdio_s};
  assign ctl_wr     = wr_strobe && reg_r == PBM_REG_CONTROL;
  assign soft_reset = ctl_wr && wdata[PBM_CTL_RESET];

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loopback_o    <= PBM_RST_LOOPBACK;
      speed_100_o   <= PBM_RST_SPEED;
      aneg_enable_o <= PBM_RST_ANEG_EN;
      power_down_o  <= PBM_RST_PWRDN;
      full_duplex_o <= PBM_RST_DUPLEX;
    end else if (soft_reset) begin
      loopback_o    <= PBM_RST_LOOPBACK;
      speed_100_o   <= PBM_RST_SPEED;
      aneg_enable_o <= PBM_RST_ANEG_EN;
      power_down_o  <= PBM_RST_PWRDN;
      full_duplex_o <= PBM_RST_DUPLEX;
    end else begin
      if (ctl_wr) begin
        loopback_o   <= wdata[PBM_CTL_LOOPBACK];
        power_down_o <= wdata[PBM_CTL_PWRDN];
        if (!fiber_s) begin
          speed_100_o   <= wdata[PBM_CTL_SPEED];
          aneg_enable_o <= wdata[PBM_CTL_ANEG_EN];
        end
        full_duplex_o <= wdata[PBM_CTL_DUPLEX];
      end else if (aneg_enable_o && done_s) begin
        full_duplex_o <= adup_s;
      end
      if (fiber_s) begin
        speed_100_o   <= 1'b1;
        aneg_enable_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= ctl_wr && !soft_reset && wdata[PBM_CTL_RESTART];
    end
  end
  assign aneg_restart_o = restart_r;

  // ********************************************************************
  // Status latches
  // ********************************************************************
  logic rfault_r;
  logic no_fail_r;
  logic sts_rd;
  logic link_was_up_r;

  assign sts_rd = rd_strobe && reg_r == PBM_REG_STATUS;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rfault_r  <= 1'b0;
      no_fail_r <= PBM_RST_NO_FAIL;
    end else if (soft_reset) begin
      rfault_r  <= 1'b0;
      no_fail_r <= PBM_RST_NO_FAIL;
    end else begin
      if (rflt_s) begin
        rfault_r <= 1'b1;
      end else if (sts_rd) begin
        rfault_r <= 1'b0;
      end
      if (!link_s && link_was_up_r) begin
        no_fail_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_was_up_r <= 1'b0;
    end else begin
      link_was_up_r <= link_s;
    end
  end

  // ********************************************************************
  // Read multiplexer
  // ********************************************************************
  always_comb begin
    rd_data = 16'h0000;
    case (reg_r)
      PBM_REG_CONTROL: begin
        rd_data[PBM_CTL_LOOPBACK] = loopback_o;
        rd_data[PBM_CTL_SPEED]    = speed_100_o | fiber_s;
        rd_data[PBM_CTL_ANEG_EN]  = aneg_enable_o & ~fiber_s;
        rd_data[PBM_CTL_PWRDN]    = power_down_o;
        rd_data[PBM_CTL_DUPLEX]   = full_duplex_o;
      end
      PBM_REG_STATUS: begin
        rd_data[PBM_STS_ABIL_HI:PBM_STS_ABIL_LO] = PBM_ABILITY;
        rd_data[PBM_STS_PRE_SUP] = 1'b1;
        rd_data[PBM_STS_ANEG_OK] = done_s;
        rd_data[PBM_STS_RFAULT]  = rfault_r | rflt_s;
        rd_data[PBM_STS_NO_FAIL] = no_fail_r;
        rd_data[PBM_STS_LINK]    = link_s;
        rd_data[PBM_STS_JABBER]  = jab_s;
        rd_data[PBM_STS_EXT_CAP] = 1'b1;
      end
      PBM_REG_ID_HIGH: rd_data = ID_HIGH_VALUE;
      PBM_REG_ID_LOW:  rd_data = ID_LOW_VALUE;
      default:         rd_data = 16'h0000;
    endcase
  end
endmodule

// ### pbm_pkg.sv
// Package for the basic management register block
package pbm_pkg;
  // ********************************************************************
  // Register indexes
  // ********************************************************************
  localparam logic [4:0] PBM_REG_CONTROL = 5'h00;
  localparam logic [4:0] PBM_REG_STATUS  = 5'h01;
  localparam logic [4:0] PBM_REG_ID_HIGH = 5'h02;
  localparam logic [4:0] PBM_REG_ID_LOW  = 5'h03;
  // ********************************************************************
  // Control field positions
  // ********************************************************************
  localparam int PBM_CTL_RESET    = 15;
  localparam int PBM_CTL_LOOPBACK = 14;
  localparam int PBM_CTL_SPEED    = 13;
  localparam int PBM_CTL_ANEG_EN  = 12;
  localparam int PBM_CTL_PWRDN    = 11;
  localparam int PBM_CTL_RESTART  = 9;
  localparam int PBM_CTL_DUPLEX   = 8;
  // ********************************************************************
  // Status field positions
  // ********************************************************************
  localparam int PBM_STS_ABIL_HI  = 15;
  localparam int PBM_STS_ABIL_LO  = 11;
  localparam int PBM_STS_PRE_SUP  = 6;
  localparam int PBM_STS_ANEG_OK  = 5;
  localparam int PBM_STS_RFAULT   = 4;
  localparam int PBM_STS_NO_FAIL  = 3;
  localparam int PBM_STS_LINK     = 2;
  localparam int PBM_STS_JABBER   = 1;
  localparam int PBM_STS_EXT_CAP  = 0;
  // ********************************************************************
  // Reset values and fixed fields
  // ********************************************************************
  localparam logic       PBM_RST_LOOPBACK = 1'b0;
  localparam logic       PBM_RST_SPEED    = 1'b1;
  localparam logic       PBM_RST_ANEG_EN  = 1'b1;
  localparam logic       PBM_RST_PWRDN    = 1'b0;
  localparam logic       PBM_RST_DUPLEX   = 1'b1;
  localparam logic       PBM_RST_NO_FAIL  = 1'b1;
  localparam logic [4:0] PBM_ABILITY      = 5'h0F;
  // ********************************************************************
  // Frame layout
  // ********************************************************************
  localparam logic [1:0] PBM_ST_CODE      = 2'h1;
  localparam logic [1:0] PBM_OP_WRITE     = 2'h1;
  localparam logic [1:0] PBM_OP_READ      = 2'h2;
  localparam logic [5:0] PBM_PREAMBLE_MIN = 6'h20;
  localparam int         PBM_SYNC_STAGES  = 2;
endpackage

// ### pbm_sync.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module pbm_sync (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// ### pbm_mgmt_props.sv
// Concurrent checks on the ports of the management register block
`timescale 1ns/1ps
module pbm_mgmt_props (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       mdc_i,
  input wire logic       mdio_o,
  input wire logic       mdio_oe_o,
  input wire logic [4:0] mgmt_address_strap_i,
  input wire logic       fiber_mode_i,
  input wire logic       aneg_done_i,
  input wire logic       aneg_duplex_i,
  input wire logic       loopback_o,
  input wire logic       speed_100_o,
  input wire logic       full_duplex_o,
  input wire logic       aneg_enable_o,
  input wire logic       aneg_restart_o,
  input wire logic       power_down_o,
  input wire logic [4:0] mgmt_address_o
);
  // ******************************************************************
  // Helper counters
  // ******************************************************************
  logic [1:0] rel_cnt_r;
  logic [4:0] low_cnt_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) rel_cnt_r <= 2'h0;
    else if (rel_cnt_r != 2'h3) rel_cnt_r <= rel_cnt_r + 2'h1;
  end
  // Cycles since the management clock was last high, saturating
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) low_cnt_r <= 5'h00;
    else if (mdc_i) low_cnt_r <= 5'h00;
    else if (low_cnt_r != 5'h1F) low_cnt_r <= low_cnt_r + 5'h01;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_RST_DEFAULTS: assert property ($rose(rstn_i) |->
    speed_100_o && aneg_enable_o && full_duplex_o && !loopback_o
    && !power_down_o && !aneg_restart_o)
    else $error("control outputs not at defaults after reset");
  AST_FIBER_SPEED: assert property (fiber_mode_i [*6] |-> speed_100_o)
    else $error("speed not forced high in fiber mode");
  AST_FIBER_ANEG: assert property (fiber_mode_i [*6] |-> !aneg_enable_o)
    else $error("negotiation enable not forced low in fiber mode");
  AST_RESTART_PULSE: assert property (aneg_restart_o |=> !aneg_restart_o)
    else $error("restart pulse longer than one cycle");
  AST_ADDR_CAPTURE: assert property ((rel_cnt_r == 2'h2) |->
    mgmt_address_o == $past(mgmt_address_strap_i))
    else $error("management address not taken from straps");
  AST_ADDR_STABLE: assert property ((rel_cnt_r == 2'h3) |->
    $stable(mgmt_address_o))
    else $error("management address changed after capture");
  AST_TA_ZERO: assert property ($rose(mdio_oe_o) |-> !mdio_o)
    else $error("turnaround bit not driven low");
  AST_OE_HOLD: assert property ($rose(mdio_oe_o) |-> mdio_oe_o [*8])
    else $error("data driver released within one clock period");
  AST_IDLE_RELEASE: assert property ((low_cnt_r == 5'h1F) |->
    !mdio_oe_o)
    else $error("data line driven while management clock idle");
  AST_DUPLEX_FOLLOW: assert property ((aneg_done_i && aneg_duplex_i
    && aneg_enable_o) [*6] |-> full_duplex_o)
    else $error("duplex does not follow negotiated result");
endmodule
bind pbm_mgmt_regs pbm_mgmt_props pbm_mgmt_props_i (
  .sys_clk_i, .rstn_i, .mdc_i, .mdio_o, .mdio_oe_o, .mgmt_address_strap_i,
  .fiber_mode_i, .aneg_done_i, .aneg_duplex_i, .loopback_o, .speed_100_o,
  .full_duplex_o, .aneg_enable_o, .aneg_restart_o, .power_down_o,
  .mgmt_address_o
);

// ### pbm_mac_model.sv
// Station management controller model driving the serial port
`timescale 1ns/1ps
module pbm_mac_model (
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  logic smp_r;
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // One bit period of 800 ns; sampled late in the high phase
  task automatic bit_out(input logic b, input logic drv);
    mdio_oe_o = drv;
    mdio_o = b;
    #400 mdc_o = 1'b1;
    #390 smp_r = mdio_i;
    #10 mdc_o = 1'b0;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       input int pre, output logic [15:0] rd);
    logic [13:0] hdr;
    hdr = {2'b01, op, pa, ra};
    #37;
    repeat (pre) bit_out(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) bit_out(hdr[i], 1'b1);
    if (op == 2'b01) begin
      bit_out(1'b1, 1'b1);
      bit_out(1'b0, 1'b1);
      for (int i = 15; i >= 0; i--) bit_out(wd[i], 1'b1);
    end else begin
      bit_out(1'b1, 1'b0);
      bit_out(1'b1, 1'b0);
      for (int i = 15; i >= 0; i--) begin
        bit_out(1'b1, 1'b0);
        rd[i] = smp_r;
      end
    end
    bit_out(1'b1, 1'b0);
  endtask
endmodule

// ### tb_top.sv
// Testbench for the basic management register block
`timescale 1ns/1ps
module tb_top;
  import pbm_pkg::*;
  localparam logic [4:0]  ADDR = 5'h0B;
  localparam logic [15:0] IDH  = 16'h0A5C; // Arbitrary value
  localparam logic [15:0] IDL  = 16'h3E71; // Arbitrary value
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic fiber = 1'b0, done = 1'b0, dup = 1'b0;
  logic rflt = 1'b0, link = 1'b0, jab = 1'b0;
  logic mdc, mac_d, mac_oe, dev_d, dev_oe, mdio_w;
  logic loop, spd, fdx, aen, arst, pdn;
  logic [4:0]  madr;
  logic [4:0]  strap = ADDR;
  logic [15:0] rd;
  int miscompares = 0, n_checks = 0, restarts = 0, pre = 32;
  always #50 sys_clk_i = ~sys_clk_i;
  // Pulled-up line shared by both drivers
  assign mdio_w = dev_oe ? dev_d : (mac_oe ? mac_d : 1'b1);
  always @(posedge sys_clk_i) if (arst === 1'b1) restarts++;
  pbm_mgmt_regs #(.ID_HIGH_VALUE(IDH), .ID_LOW_VALUE(IDL)) pbm_mgmt_regs_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(dev_d), .mdio_oe_o(dev_oe), .mgmt_address_strap_i(strap),
    .fiber_mode_i(fiber), .aneg_done_i(done), .aneg_duplex_i(dup),
    .remote_fault_i(rflt), .link_up_i(link), .jabber_i(jab),
    .loopback_o(loop), .speed_100_o(spd), .full_duplex_o(fdx),
    .aneg_enable_o(aen), .aneg_restart_o(arst), .power_down_o(pdn),
    .mgmt_address_o(madr));
  pbm_mac_model pbm_mac_model_i (.mdio_i(mdio_w), .mdc_o(mdc),
    .mdio_o(mac_d), .mdio_oe_o(mac_oe));
  task automatic chk(input logic [15:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [4:0] pa, ra);
    pbm_mac_model_i.frame(PBM_OP_READ, pa, ra, 16'h0000, pre, rd);
    pre = 0;
  endtask
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    rd_reg(ADDR, ra);
    chk(rd, exp, "register read");
  endtask
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
    pbm_mac_model_i.frame(PBM_OP_WRITE, ADDR, ra, wd, pre, rd);
    pre = 0;
    repeat (12) @(posedge sys_clk_i);
  endtask
  // Order: loopback, speed, enable, power down, duplex
  task automatic outs_chk(input logic [4:0] exp);
    chk({11'h000, loop, spd, aen, pdn, fdx}, {11'h000, exp}, "outputs");
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #6_000_000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    // Straps move after capture; the captured address must not follow
    strap <= 5'h0C;
    chk({11'h000, madr}, {11'h000, ADDR}, "address");
    outs_chk(5'b01101);
    rd_chk(PBM_REG_CONTROL, 16'h3100);
    rd_chk(PBM_REG_STATUS, 16'h7849);
    rd_chk(PBM_REG_ID_HIGH, IDH);
    rd_chk(PBM_REG_ID_LOW, IDL);
    rd_chk(5'h07, 16'h0000);
    rd_reg(5'h0C, PBM_REG_CONTROL);
    chk(rd, 16'hFFFF, "foreign address answered");
    chk({11'h000, madr}, {11'h000, ADDR}, "address held");
    wr_reg(PBM_REG_ID_HIGH, 16'hFFFF);
    rd_chk(PBM_REG_ID_HIGH, IDH);
    wr_reg(PBM_REG_CONTROL, 16'h4CFF);
    rd_chk(PBM_REG_CONTROL, 16'h4800);
    outs_chk(5'b10010);
    wr_reg(PBM_REG_CONTROL, 16'h1200);
    chk(16'(restarts), 16'h0001, "restart pulses");
    @(posedge sys_clk_i);
    fiber <= 1'b1;
    wr_reg(PBM_REG_CONTROL, 16'h1000);
    rd_chk(PBM_REG_CONTROL, 16'h2000);
    outs_chk(5'b01000);
    @(posedge sys_clk_i);
    fiber <= 1'b0;
    {done, dup, link, jab, rflt} <= 5'b11111;
    wr_reg(PBM_REG_CONTROL, 16'h3000);
    rflt <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rd_chk(PBM_REG_CONTROL, 16'h3100);
    rd_chk(PBM_REG_STATUS, 16'h787F);
    @(posedge sys_clk_i);
    link <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rd_chk(PBM_REG_STATUS, 16'h7863);
    wr_reg(PBM_REG_CONTROL, 16'hC000);
    rd_chk(PBM_REG_CONTROL, 16'h3100);
    rd_chk(PBM_REG_STATUS, 16'h786B);
    final_report;
  end
endmodule
